// file: rtl/cwsc_ctrl.sv
// Control logic of a complementary waveform generator with auto-shutdown.
// Assumes inputs synchronous to aclk; dead-band counting runs on aclk.
// Summary of operation
// - Software setting shutdown flag forces outputs to override levels at once.
// - Without auto-resume, shutdown lasts while the flag stays set.
// - With auto-resume, hardware clears the flag and restarts on data rise.
// - Five kill sources each enabled; any enabled low source shuts down.
// - Enabled active source overrides outputs immediately, no added delay.
// - Sources are levels; shutdown holds until source ends or is disabled.
// - One field sets B and D levels, another sets A and C.
// - Every entry into shutdown sets the generator interrupt flag.
// - No restart until every shutdown cause is gone.
// - With auto-resume, hardware clears the flag once causes end.
// - After flag clears, output resumes at first data rising edge.
// - Software zero write to flag ignored while a cause is active.
// - Keeps working in sleep; oscillator clock keeps dead band running.
// - Enabling starts in shutdown with override levels applied.
// - Enable is bit 7; bit 6 reloads gap buffers after fall-rise.
// - Reload request accepted only when already enabled.
// - Three-bit mode selects steering, bridge, half-bridge, push-pull modes.
// - Bit 5 of second control reads selected data level, read-only.
// - Bits 3..0 invert outputs D, C, B, A when set.
// - Clock select zero picks system clock, one internal oscillator.
// - Four-bit data select picks source; codes 14 and 15 reserved.
// - Override codes: one, zero, tri-state, inactive level set by the polarity bit.
// - Dead band may exceed programmed count by one clock.
`timescale 1ns/10ps
module cwsc_ctrl
  import cwsc_pkg::*;
#(
  parameter int GAP_W = 6
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Data sources, index equals data select code
  input  wire logic [13:0] data_sources,
  // Kill sources, active low
  input  wire logic        pin_select_input,
  input  wire logic        comparator1_result,
  input  wire logic        comparator2_result,
  input  wire logic        logic_cell2_out,
  input  wire logic        logic_cell4_out,
  // Clocking choice seen by the clock mux outside
  output logic             osc_clock_select,
  // Outputs A..D with enables
  output logic             drive_out_a,
  output logic             drive_out_b,
  output logic             drive_out_c,
  output logic             drive_out_d,
  output logic [3:0]       drive_oe,
  output logic             generator_irq_flag
);
  typedef struct packed {
    logic        aw_got;  logic [5:0] aw_addr;
    logic        w_got;   logic [31:0] w_data; logic [3:0] w_strb;
    logic        bvalid;  logic [1:0] bresp;
    logic        rvalid;  logic [31:0] rdata; logic [1:0] rresp;
    logic        enable;  logic reload; logic [2:0] mode;
    logic [3:0]  output_invert;
    logic        clk_sel; logic [3:0] data_source_field;
    logic [3:0]  steer_data; logic [3:0] steer_select;
    logic        shutdown; logic ren;
    logic [1:0]  bd_override_level; logic [1:0] ac_override_level;
    logic [4:0]  kill_source_enables;
    logic [GAP_W-1:0] rise_gap_count; logic [GAP_W-1:0] fall_gap_count;
    logic [GAP_W-1:0] rise_buf; logic [GAP_W-1:0] fall_buf;
    logic        reload_armed; logic data_q; logic running;
    logic [GAP_W-1:0] gap_cnt;
    logic [3:0]  wave; logic irq;
  } cwsc_state_t;
  cwsc_state_t st, next_st;

  logic       data_in;
  logic [4:0] kill_active;
  logic       kill_any;
  logic [7:0] reg_rd;
  logic       data_rise, data_fall, wr_fire, rd_fire;
  logic [3:0] level, ovr;

  function automatic logic [7:0] cwsc_read(input cwsc_state_t s, input logic [5:0] a,
                                            input logic din);
    case (a)
      CWSC_OFS_CONTROL:  cwsc_read = {s.enable, s.reload, 3'h0, s.mode};
      CWSC_OFS_POLARITY: cwsc_read = {2'h0, din, 1'h0, s.output_invert};
      CWSC_OFS_CLKSEL:   cwsc_read = {7'h00, s.clk_sel};
      CWSC_OFS_DATASEL:  cwsc_read = {4'h0, s.data_source_field};
      CWSC_OFS_STEER:    cwsc_read = {s.steer_data, s.steer_select};
      CWSC_OFS_HALT0:    cwsc_read = {s.shutdown, s.ren, s.bd_override_level,
                                      s.ac_override_level, 2'h0};
      CWSC_OFS_HALT1:    cwsc_read = {3'h0, s.kill_source_enables};
      CWSC_OFS_RISEGAP:  cwsc_read = 8'(s.rise_gap_count);
      CWSC_OFS_FALLGAP:  cwsc_read = 8'(s.fall_gap_count);
      CWSC_OFS_IRQ:      cwsc_read = {7'h00, s.irq};
      default:           cwsc_read = 8'h00;
    endcase
  endfunction

  function automatic logic cwsc_mapped(input logic [5:0] a);
    cwsc_mapped = (a <= CWSC_OFS_IRQ) && (a[1:0] == 2'b00);
  endfunction

  // Reserved select codes give a low data input
  assign data_in = (st.data_source_field < 4'he) ? data_sources[st.data_source_field] : 1'b0;
  // Enables 0..4: pin select, comparator 1, comparator 2, cell 2, cell 4
  assign kill_active = st.kill_source_enables &
                       ~{logic_cell4_out, logic_cell2_out, comparator2_result,
                         comparator1_result, pin_select_input};
  assign kill_any  = |kill_active;
  assign data_rise = data_in & ~st.data_q;
  assign data_fall = ~data_in & st.data_q;
  assign wr_fire   = st.aw_got & st.w_got & ~st.bvalid;
  assign rd_fire   = s_axi_arvalid & s_axi_arready;
  assign reg_rd    = cwsc_read(st, s_axi_araddr, data_in);

  always_comb begin
    next_st = st;
    if (s_axi_awvalid && !st.aw_got) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, reg_rd};
      next_st.rresp  = cwsc_mapped(s_axi_araddr) ? CWSC_RESP_OKAY : CWSC_RESP_SLVERR;
    end
    next_st.data_q = data_in;
    // Dead-band counter; data sampled on aclk gives up to one clock of jitter
    if (data_rise || data_fall) begin
      next_st.gap_cnt = '0;
    end else if (st.gap_cnt != {GAP_W{1'b1}}) begin
      next_st.gap_cnt = st.gap_cnt + 1'b1;
    end
    // Buffered reload: arm on first fall, load on following rise
    if (st.reload && data_fall) begin
      next_st.reload_armed = 1'b1;
    end
    if (st.reload_armed && data_rise) begin
      next_st.rise_buf     = st.rise_gap_count;
      next_st.fall_buf     = st.fall_gap_count;
      next_st.reload       = 1'b0;
      next_st.reload_armed = 1'b0;
    end
    if (!st.enable) begin
      next_st.rise_buf = st.rise_gap_count;
      next_st.fall_buf = st.fall_gap_count;
      // A pending reload must not survive a disable
      next_st.reload       = 1'b0;
      next_st.reload_armed = 1'b0;
    end
    // Waveform: in half-bridge and push-pull, A/C follow data, B/D complementary, gapped after an edge
    case (cwsc_mode_t'(st.mode))
      CWSC_M_ASTEER, CWSC_M_SSTEER:
        next_st.wave = {4{data_in}};
      CWSC_M_FWD:
        next_st.wave = {data_in, 1'b0, 1'b0, 1'b1};
      CWSC_M_REV:
        next_st.wave = {1'b0, 1'b1, data_in, 1'b0};
      CWSC_M_HALF, CWSC_M_PP: begin
        next_st.wave[0] = data_in & (st.gap_cnt >= st.rise_buf);
        next_st.wave[1] = ~data_in & (st.gap_cnt >= st.fall_buf);
        next_st.wave[2] = next_st.wave[0];
        next_st.wave[3] = next_st.wave[1];
      end
      default:
        next_st.wave = 4'h0;
    endcase
    if (!st.shutdown && !kill_any && data_rise) begin
      next_st.running = 1'b1;
    end
    // Hardware sets win over clears
    if (kill_any) begin
      next_st.shutdown = 1'b1;
    end else if (st.ren && st.shutdown) begin
      next_st.shutdown = 1'b0;
    end
    if (st.shutdown || kill_any) begin
      next_st.running = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = cwsc_mapped(st.aw_addr) ? CWSC_RESP_OKAY : CWSC_RESP_SLVERR;
      if (st.w_strb[0]) begin
        case (st.aw_addr)
          CWSC_OFS_CONTROL: begin
            next_st.enable = st.w_data[CWSC_BIT_EN];
            next_st.mode   = st.w_data[2:0];
            if (st.enable && st.w_data[CWSC_BIT_EN] && st.w_data[CWSC_BIT_RELOAD]) begin
              next_st.reload = 1'b1;
            end
            if (!st.w_data[CWSC_BIT_EN]) begin
              next_st.reload       = 1'b0;
              next_st.reload_armed = 1'b0;
            end
            if (!st.enable && st.w_data[CWSC_BIT_EN]) begin
              next_st.shutdown = 1'b1;
              next_st.running  = 1'b0;
            end
          end
          CWSC_OFS_POLARITY: next_st.output_invert = st.w_data[3:0];
          CWSC_OFS_CLKSEL:   next_st.clk_sel = st.w_data[0];
          CWSC_OFS_DATASEL:  next_st.data_source_field = st.w_data[3:0];
          CWSC_OFS_STEER: begin
            next_st.steer_data   = st.w_data[7:4];
            next_st.steer_select = st.w_data[3:0];
          end
          CWSC_OFS_HALT0: begin
            next_st.ren = st.w_data[CWSC_BIT_REN];
            next_st.bd_override_level = st.w_data[CWSC_POS_BD +: 2];
            next_st.ac_override_level = st.w_data[CWSC_POS_AC +: 2];
            if (st.w_data[CWSC_BIT_SHUTDOWN]) begin
              next_st.shutdown = 1'b1;
              next_st.running  = 1'b0;
            end else if (!kill_any && !(st.ren && st.shutdown)) begin
              next_st.shutdown = 1'b0;
            end
          end
          CWSC_OFS_HALT1:   next_st.kill_source_enables = st.w_data[4:0];
          CWSC_OFS_RISEGAP: next_st.rise_gap_count = st.w_data[GAP_W-1:0];
          CWSC_OFS_FALLGAP: next_st.fall_gap_count = st.w_data[GAP_W-1:0];
          CWSC_OFS_IRQ:     next_st.irq = st.irq & ~st.w_data[0];
          default: ;
        endcase
      end
    end
    if (next_st.shutdown && !st.shutdown) begin
      next_st.irq = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                   <= '0;
      st.bd_override_level <= CWSC_RST_HALT0[CWSC_POS_BD +: 2];
      st.ac_override_level <= CWSC_RST_HALT0[CWSC_POS_AC +: 2];
    end else begin
      st <= next_st;
    end
  end

  // Outputs: live kill sources override without waiting for an edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      logic [1:0] code;
      logic       pol_wave;
      assign code = gi[0] ? st.bd_override_level : st.ac_override_level;
      assign pol_wave = ((st.mode[2:1] == 2'b00 && !st.steer_select[gi]) ?
                         st.steer_data[gi] : st.wave[gi]) ^ st.output_invert[gi];
      always_comb begin
        case (code)
          CWSC_LVL_ONE:  ovr[gi] = 1'b1;
          CWSC_LVL_ZERO: ovr[gi] = 1'b0;
          CWSC_LVL_HIZ:  ovr[gi] = 1'b0;
          default:       ovr[gi] = st.output_invert[gi];
        endcase
        if (!st.enable) begin
          level[gi] = 1'b0;
        end else if (st.shutdown || kill_any || !st.running) begin
          level[gi] = ovr[gi];
        end else begin
          level[gi] = pol_wave;
        end
      end
      assign drive_oe[gi] = !(st.enable && (st.shutdown || kill_any || !st.running) &&
                              code == CWSC_LVL_HIZ);
    end
  endgenerate

  assign drive_out_a = level[0];
  assign drive_out_b = level[1];
  assign drive_out_c = level[2];
  assign drive_out_d = level[3];
  assign generator_irq_flag = st.irq;
  assign osc_clock_select   = st.clk_sel;
  assign s_axi_awready = ~st.aw_got;
  assign s_axi_wready  = ~st.w_got;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  a_kill_override: assert property (@(posedge aclk) disable iff (!aresetn)
    st.enable && kill_any |-> level == ovr) else $error("kill did not override");
  a_kill_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    kill_any |=> st.shutdown) else $error("kill did not set shutdown");
  a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    st.shutdown && !st.ren && !wr_fire |=> st.shutdown) else $error("shutdown dropped");
  a_auto_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    st.shutdown && st.ren && !kill_any && !wr_fire |=> !st.shutdown)
    else $error("auto resume failed");
  a_irq_on_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.shutdown ##1 st.shutdown |-> st.irq) else $error("irq not set");
  a_no_clear_kill: assert property (@(posedge aclk) disable iff (!aresetn)
    kill_any |=> st.shutdown ##0 !st.running) else $error("cleared under kill");
  a_resume_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.running ##1 st.running |-> $past(data_rise)) else $error("resume off edge");
  a_reload_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.enable |=> !st.reload) else $error("reload while disabled");
  a_start_shut: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st.enable) |-> st.shutdown) else $error("enable not in shutdown");

  // Steps of a software write to the shutdown register
  sequence s_halt0_write;
    wr_fire && st.aw_addr == CWSC_OFS_HALT0 && st.w_strb[0];
  endsequence

  sequence s_soft_shut;
    s_halt0_write ##0 st.w_data[CWSC_BIT_SHUTDOWN];
  endsequence

  sequence s_soft_clear;
    s_halt0_write ##0 !st.w_data[CWSC_BIT_SHUTDOWN];
  endsequence

  // Flag falls: output must still wait for a data rise
  sequence s_flag_drop;
    st.shutdown ##1 !st.shutdown;
  endsequence

  a_soft_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    s_soft_shut |=> st.shutdown && st.irq) else $error("soft shutdown missed");
  a_clear_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_soft_clear ##0 kill_any |=> st.shutdown) else $error("clear taken under kill");
  a_hold_to_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    s_flag_drop |-> !st.running) else $error("resumed before data rise");
  a_hiz_release: assert property (@(posedge aclk) disable iff (!aresetn)
    st.enable && st.shutdown && st.bd_override_level == CWSC_LVL_HIZ |->
    !drive_oe[1] && !drive_oe[3]) else $error("tri-state not released");
  a_idle_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.enable |-> level == 4'h0 && drive_oe == 4'hf)
    else $error("outputs active while off");
  // While enabled, buffers take the programmed counts only at the armed rise
  a_reload_load: assert property (@(posedge aclk) disable iff (!aresetn)
    st.enable && st.reload_armed && data_rise && !wr_fire |=>
    !st.reload && st.rise_buf == $past(st.rise_gap_count))
    else $error("gap buffers not reloaded");
endmodule

// file: rtl/cwsc_pkg.sv
// Package for the complementary waveform shutdown controller.
// Assumes a single 40 MHz system clock and an AXI4-Lite register bus.
package cwsc_pkg;
  localparam logic [5:0] CWSC_OFS_CONTROL  = 6'h00;
  localparam logic [5:0] CWSC_OFS_POLARITY = 6'h04;
  localparam logic [5:0] CWSC_OFS_CLKSEL   = 6'h08;
  localparam logic [5:0] CWSC_OFS_DATASEL  = 6'h0c;
  localparam logic [5:0] CWSC_OFS_STEER    = 6'h10;
  localparam logic [5:0] CWSC_OFS_HALT0    = 6'h14;
  localparam logic [5:0] CWSC_OFS_HALT1    = 6'h18;
  localparam logic [5:0] CWSC_OFS_RISEGAP  = 6'h1c;
  localparam logic [5:0] CWSC_OFS_FALLGAP  = 6'h20;
  localparam logic [5:0] CWSC_OFS_IRQ      = 6'h24;
  // Field positions
  localparam int CWSC_BIT_EN       = 7;
  localparam int CWSC_BIT_RELOAD   = 6;
  localparam int CWSC_BIT_IN       = 5;
  localparam int CWSC_BIT_SHUTDOWN = 7;
  localparam int CWSC_BIT_REN      = 6;
  localparam int CWSC_POS_BD       = 4;
  localparam int CWSC_POS_AC       = 2;
  // Reset values
  localparam logic [7:0] CWSC_RST_HALT0 = 8'h14;
  localparam logic [7:0] CWSC_RST_ZERO  = 8'h00;
  localparam logic [1:0] CWSC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CWSC_RESP_SLVERR = 2'b10;
  // Override level codes
  localparam logic [1:0] CWSC_LVL_ONE  = 2'b11;
  localparam logic [1:0] CWSC_LVL_ZERO = 2'b10;
  localparam logic [1:0] CWSC_LVL_HIZ  = 2'b01;
  localparam logic [1:0] CWSC_LVL_IDLE = 2'b00;
  typedef enum logic [2:0] {
    CWSC_M_ASTEER, CWSC_M_SSTEER, CWSC_M_FWD, CWSC_M_REV, CWSC_M_HALF, CWSC_M_PP,
    CWSC_M_RSV6, CWSC_M_RSV7
  } cwsc_mode_t;
endpackage

// file: verification/complementary_waveform_shutdown_ctrl_test.sv
// Self-checking bench for the waveform shutdown controller.
// Assumes a 40 MHz aclk and an AXI4-Lite master built from tasks.
`timescale 1ns/10ps
module complementary_waveform_shutdown_ctrl_test;
  import cwsc_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, osc_clock_select, generator_irq_flag, src_level;
  logic        drive_out_a, drive_out_b, drive_out_c, drive_out_d;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, drive_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [13:0] data_sources, src_mask;
  logic [4:0]  kill_req, kill_n;
  int          num_errors, tests_run;

  cwsc_ctrl cwsc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .data_sources, .pin_select_input(kill_n[0]),
    .comparator1_result(kill_n[1]), .comparator2_result(kill_n[2]),
    .logic_cell2_out(kill_n[3]), .logic_cell4_out(kill_n[4]), .osc_clock_select,
    .drive_out_a, .drive_out_b, .drive_out_c, .drive_out_d, .drive_oe, .generator_irq_flag);
  cwsc_far_model cwsc_far_model_i (.src_mask, .src_level, .kill_req, .data_sources, .kill_n);

  always #12.5 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is sampled at the falling edge; inputs only move after rising edges
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic aw_ok, w_ok, ta, tw;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (tw) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ok = s_axi_arready;
      @(posedge aclk);
    end while (ok !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(what, {24'h0, exp}, d);
  endtask

  task automatic ochk(input string what, input logic [3:0] exp);
    chk(what, {28'h0, exp}, {28'h0, drive_out_d, drive_out_c, drive_out_b, drive_out_a});
  endtask

  // A fresh rising edge on the selected data input
  task automatic rise();
    @(posedge aclk) src_level <= 1'b0;
    repeat (3) @(posedge aclk);
    src_level <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rchk("control", CWSC_OFS_CONTROL, 8'h00);
    rchk("clksel", CWSC_OFS_CLKSEL, 8'h00);
    rchk("datasel", CWSC_OFS_DATASEL, 8'h00);
    rchk("halt0", CWSC_OFS_HALT0, CWSC_RST_HALT0);
    rchk("halt1", CWSC_OFS_HALT1, 8'h00);
    rd(6'h3c, d, r);
    chk("unmapped resp", {30'h0, CWSC_RESP_SLVERR}, {30'h0, r});
  endtask

  task automatic t_regs();
    for (int m = 0; m < 6; m++) begin
      wr(CWSC_OFS_CONTROL, 8'(m));
      rchk("mode", CWSC_OFS_CONTROL, 8'(m));
    end
    wr(CWSC_OFS_CONTROL, 8'hc0);
    rchk("reload with enable", CWSC_OFS_CONTROL, 8'h80);
    wr(CWSC_OFS_CONTROL, 8'hc0);
    rchk("reload pending", CWSC_OFS_CONTROL, 8'hc0);
    wr(CWSC_OFS_CONTROL, 8'h00);
    wr(CWSC_OFS_CLKSEL, 8'h01);
    chk("osc select", 32'h1, {31'h0, osc_clock_select});
    wr(CWSC_OFS_CLKSEL, 8'h00);
    chk("sys select", 32'h0, {31'h0, osc_clock_select});
    src_level <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      src_mask <= 14'h1 << c;
      wr(CWSC_OFS_DATASEL, 8'(c));
      rchk("input view", CWSC_OFS_POLARITY, (c < 14) ? 8'h20 : 8'h00);
    end
    src_mask <= 14'h1;
    src_level <= 1'b0;
    wr(CWSC_OFS_DATASEL, 8'h00);
    wr(CWSC_OFS_POLARITY, 8'h25);
    rchk("view read-only", CWSC_OFS_POLARITY, 8'h05);
  endtask

  task automatic t_soft();
    wr(CWSC_OFS_STEER, 8'h0f);
    wr(CWSC_OFS_HALT0, 8'h2c);
    wr(CWSC_OFS_HALT1, 8'h00);
    wr(CWSC_OFS_CONTROL, 8'h80);
    ochk("start override", 4'b0101);
    wr(CWSC_OFS_HALT0, 8'h2c);
    wr(CWSC_OFS_IRQ, 8'h01);
    wr(CWSC_OFS_HALT0, 8'hac);
    ochk("soft override", 4'b0101);
    chk("irq soft", 32'h1, {31'h0, generator_irq_flag});
    rise();
    ochk("held in shutdown", 4'b0101);
    wr(CWSC_OFS_HALT0, 8'h2c);
    rchk("soft clear", CWSC_OFS_HALT0, 8'h2c);
    ochk("wait for rise", 4'b0101);
    rise();
    ochk("resumed", 4'b1010);
  endtask

  task automatic t_kill();
    for (int i = 0; i < 5; i++) begin
      wr(CWSC_OFS_HALT1, 8'(1 << i));
      wr(CWSC_OFS_IRQ, 8'h01);
      @(posedge aclk) kill_req <= 5'(1 << ((i + 1) % 5));
      repeat (3) @(posedge aclk);
      #1 ochk("disabled source", 4'b1010);
      @(posedge aclk) kill_req <= 5'(1 << i) | 5'(1 << ((i + 1) % 5));
      #1 ochk("kill override", 4'b0101);
      wr(CWSC_OFS_HALT0, 8'h2c);
      rchk("clear refused", CWSC_OFS_HALT0, 8'hac);
      chk("irq kill", 32'h1, {31'h0, generator_irq_flag});
      @(posedge aclk) kill_req <= 5'h00;
      wr(CWSC_OFS_HALT0, 8'h2c);
      rchk("clear after kill", CWSC_OFS_HALT0, 8'h2c);
      rise();
      ochk("kill resumed", 4'b1010);
    end
  endtask

  task automatic t_auto();
    wr(CWSC_OFS_HALT1, 8'h01);
    wr(CWSC_OFS_HALT0, 8'h6c);
    @(posedge aclk) kill_req <= 5'h01;
    #1 ochk("auto kill", 4'b0101);
    rchk("auto held", CWSC_OFS_HALT0, 8'hec);
    wr(CWSC_OFS_HALT1, 8'h00);
    repeat (4) @(posedge aclk);
    rchk("auto clear", CWSC_OFS_HALT0, 8'h6c);
    ochk("auto wait rise", 4'b0101);
    rise();
    ochk("auto resumed", 4'b1010);
    wr(CWSC_OFS_HALT0, 8'hec);
    repeat (4) @(posedge aclk);
    rchk("auto soft clear", CWSC_OFS_HALT0, 8'h6c);
    rise();
    ochk("auto soft resumed", 4'b1010);
    kill_req <= 5'h00;
  endtask

  task automatic t_hiz();
    wr(CWSC_OFS_HALT0, 8'h9c);
    chk("tri-state bd", 32'h5, {28'h0, drive_oe});
    chk("one ac", 32'h3, {30'h0, drive_out_c, drive_out_a});
  endtask

  task automatic results();
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    results();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, src_level, kill_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    src_mask = 14'h1;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_soft();
    t_kill();
    t_auto();
    t_hiz();
    results();
  end
endmodule

// file: verification/cwsc_far_model.sv
// Far-side model: selectable data sources and active-low kill lines.
// Assumes the bench changes its requests just after aclk rises.
`timescale 1ns/10ps
module cwsc_far_model (
  // Requests from the bench
  input  wire logic [13:0] src_mask,
  input  wire logic        src_level,
  input  wire logic [4:0]  kill_req,
  // Toward the block
  output logic      [13:0] data_sources,
  output logic      [4:0]  kill_n
);
  // Unselected sources sit low rather than echoing an old level
  assign data_sources = src_mask & {14{src_level}};
  // Released kill lines idle high, as with a pull-up
  assign kill_n = ~kill_req;
endmodule
